// ===== hdl/monitor_pkg.sv
`default_nettype none
package monitor_pkg;
   localparam int CLK_MHZ = 250;
   localparam int WAKE_TIME_US = 400;
   localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;
   localparam int INTERVAL_DEF_NS = 10400;
   localparam int INTERVAL_DEF_CYC = INTERVAL_DEF_NS * CLK_MHZ / 1000;
   localparam int STAGE_CYCLES = 16;
   localparam logic [7:0] HIGH_THR_RST = 8'hFF;
   localparam logic [7:0] LOW_THR_RST = 8'h00;
   localparam logic [3:0] DISC_GAIN_RST = 4'h0;
   // Commands carried on the serial control port.
   typedef enum logic [3:0] {
      CMD_NOP, CMD_GENERAL_RESET, CMD_XTAL_SAVE, CMD_XTAL_RUN, CMD_SET_THRESH,
      CMD_SET_INTERVAL, CMD_SET_SOURCE, CMD_SET_MASK, CMD_SET_DECODERS,
      CMD_WAKE_RX, CMD_WAKE_TX, CMD_SLEEP, CMD_READ_STATUS, CMD_READ_RESULT,
      CMD_SET_OPTIONS
   } cmd_t;
   typedef enum logic [1:0] {SRC_MONITOR, SRC_FIRST_MICROPHONE_INPUT, SRC_INPUT2, SRC_DISC} source_t;
   localparam int ST_HIGH = 0;
   localparam int ST_LOW = 1;
   localparam int ST_DETECT = 2;
   localparam int STATUS_W = 8;
   localparam int DEC_W = 6;
endpackage : monitor_pkg
`default_nettype wire

// ===== hdl/monitor_if.sv
`default_nettype none
interface monitor_if;
   logic cmd_valid;
   logic [3:0] cmd;
   logic [15:0] cmd_data;
   logic [15:0] rsp_data;
   logic rsp_valid;
   logic interrupt_request_line_low;
   modport device (input cmd_valid, cmd, cmd_data, output rsp_data, rsp_valid,
      interrupt_request_line_low);
   modport host (output cmd_valid, cmd, cmd_data, input rsp_data, rsp_valid,
      interrupt_request_line_low);
endinterface : monitor_if
`default_nettype wire

// ===== hdl/monitor_device.sv
`default_nettype none
module monitor_device
   import monitor_pkg::*;
#(
   parameter int WAKE_LIMIT = monitor_pkg::WAKE_CYCLES,
   parameter int INTERVAL_MAX_W = 24
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   monitor_if.device bus,
   input wire logic [7:0] sample_monitor_i,
   input wire logic [7:0] sample_first_microphone_input_i,
   input wire logic [7:0] sample_input2_i,
   input wire logic [7:0] sample_disc_i,
   input wire logic [5:0] detect_i,
   input wire logic companding_i,
   input wire logic voice_active_i,
   output logic xtal_run_o,
   output logic bias_on_o,
   output logic rx_awake_o,
   output logic tx_awake_o,
   output logic [2:0] stage_en_o,
   output logic audio_at_bias_o,
   output logic audio_to_mod_o,
   output logic [monitor_pkg::DEC_W-1:0] decoder_en_o,
   output logic [3:0] disc_gain_o,
   output logic voice_only_o,
   output logic [7:0] result_o
);
   import monitor_pkg::*;
   typedef enum {P_SLEEP, P_STAGE, P_AWAKE} phase_t;
   logic [7:0] s0_r [4];
   logic [7:0] s1_r [4];
   logic [7:0] samples [4];
   assign samples[0] = sample_monitor_i;
   assign samples[1] = sample_first_microphone_input_i;
   assign samples[2] = sample_input2_i;
   assign samples[3] = sample_disc_i;
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_sync
         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               s0_r[g] <= 8'h00;
               s1_r[g] <= 8'h00;
            end else begin
               s0_r[g] <= samples[g];
               s1_r[g] <= s0_r[g];
            end
         end
      end
   endgenerate
   logic xtal_r, xtal_nxt, bias_r, bias_nxt, auto_r, auto_nxt, mod_r, mod_nxt;
   logic rx_r, rx_nxt, tx_r, tx_nxt, rsp_v_r, rsp_v_nxt;
   logic [7:0] hi_r, hi_nxt, lo_r, lo_nxt, res_r, res_nxt;
   logic [STATUS_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
   logic [DEC_W-1:0] dec_r, dec_nxt;
   logic [1:0] src_r, src_nxt;
   logic [3:0] gain_r, gain_nxt;
   logic [INTERVAL_MAX_W-1:0] ivl_r, ivl_nxt, icnt_r, icnt_nxt;
   logic [15:0] rsp_r, rsp_nxt;
   logic [7:0] wcnt_r, wcnt_nxt;
   phase_t ph_r, ph_nxt;
   logic conv, above, below, wake_req;
   assign conv = (icnt_r == '0);
   assign above = conv && (s1_r[src_r] > hi_r);
   assign below = conv && (s1_r[src_r] < lo_r);
   assign wake_req = above && auto_r && (src_r == 2'(SRC_DISC));
   always_comb begin
      ev = '0;
      ev[ST_HIGH] = above;
      ev[ST_LOW] = below;
      ev[ST_DETECT +: DEC_W] = detect_i & dec_r;
   end
   always_comb begin
      xtal_nxt = xtal_r;
      bias_nxt = bias_r;
      auto_nxt = auto_r;
      hi_nxt = hi_r;
      lo_nxt = lo_r;
      ivl_nxt = ivl_r;
      src_nxt = src_r;
      mask_nxt = mask_r;
      dec_nxt = dec_r;
      gain_nxt = gain_r;
      rx_nxt = rx_r;
      tx_nxt = tx_r;
      rsp_nxt = rsp_r;
      rsp_v_nxt = 1'b0;
      stat_nxt = stat_r;
      icnt_nxt = conv ? ivl_r : icnt_r - 1'b1;
      res_nxt = conv ? s1_r[src_r] : res_r;
      if (bus.cmd_valid) begin
         case (cmd_t'(bus.cmd))
            CMD_GENERAL_RESET: begin
               bias_nxt = 1'b0;
               hi_nxt = HIGH_THR_RST;
               lo_nxt = LOW_THR_RST;
               src_nxt = 2'(SRC_MONITOR);
               mask_nxt = '0;
               stat_nxt = '0;
               rx_nxt = 1'b0;
               tx_nxt = 1'b0;
               auto_nxt = 1'b0;
               dec_nxt = '0;
               gain_nxt = DISC_GAIN_RST;
               ivl_nxt = INTERVAL_MAX_W'(INTERVAL_DEF_CYC);
            end
            CMD_XTAL_SAVE: xtal_nxt = 1'b0;
            CMD_XTAL_RUN: xtal_nxt = 1'b1;
            CMD_SET_THRESH: begin
               hi_nxt = bus.cmd_data[15:8];
               lo_nxt = bus.cmd_data[7:0];
            end
            CMD_SET_INTERVAL: ivl_nxt = INTERVAL_MAX_W'(bus.cmd_data);
            CMD_SET_SOURCE: src_nxt = bus.cmd_data[1:0];
            CMD_SET_MASK: mask_nxt = bus.cmd_data[STATUS_W-1:0];
            CMD_SET_DECODERS: begin
               // Bits 2..5 are the voice-band options; bit 5 is selcall with 2400 data.
               if (!(voice_active_i && ($countones(bus.cmd_data[5:2]) > 1))
                   && !(companding_i && bus.cmd_data[5])) begin
                  dec_nxt = bus.cmd_data[DEC_W-1:0];
               end
            end
            CMD_SET_OPTIONS: begin
               bias_nxt = bus.cmd_data[0];
               auto_nxt = bus.cmd_data[1];
               gain_nxt = bus.cmd_data[7:4];
            end
            CMD_WAKE_RX: begin
               rx_nxt = 1'b1;
               tx_nxt = 1'b0;
            end
            CMD_WAKE_TX: begin
               tx_nxt = 1'b1;
               rx_nxt = 1'b0;
            end
            CMD_SLEEP: begin
               rx_nxt = 1'b0;
               tx_nxt = 1'b0;
            end
            CMD_READ_STATUS: begin
               rsp_nxt = {8'h00, stat_r};
               rsp_v_nxt = 1'b1;
               stat_nxt = '0;
            end
            CMD_READ_RESULT: begin
               rsp_nxt = {8'h00, res_r};
               rsp_v_nxt = 1'b1;
            end
            default: begin
            end
         endcase
      end
      if (wake_req) rx_nxt = 1'b1;
      stat_nxt = stat_nxt | ev;
   end
   always_comb begin
      ph_nxt = ph_r;
      wcnt_nxt = wcnt_r;
      mod_nxt = mod_r;
      case (ph_r)
         P_SLEEP: if (rx_r || tx_r) begin
            ph_nxt = P_STAGE;
            wcnt_nxt = '0;
         end
         P_STAGE: begin
            wcnt_nxt = wcnt_r + 1'b1;
            if (wcnt_r == 8'(STAGE_CYCLES * 3 - 1)) ph_nxt = P_AWAKE;
            if (wcnt_r == 8'(STAGE_CYCLES - 1)) mod_nxt = tx_r;
            if (!(rx_r || tx_r)) ph_nxt = P_SLEEP;
         end
         default: begin
            if (!(rx_r || tx_r)) begin
               ph_nxt = P_SLEEP;
            end else if (tx_r != mod_r) begin
               // A change of direction is rerouted through the staged sequence.
               ph_nxt = P_STAGE;
               wcnt_nxt = '0;
            end
         end
      endcase
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         xtal_r <= 1'b1;
         bias_r <= 1'b0;
         auto_r <= 1'b0;
         hi_r <= HIGH_THR_RST;
         lo_r <= LOW_THR_RST;
         ivl_r <= INTERVAL_MAX_W'(INTERVAL_DEF_CYC);
         icnt_r <= '0;
         res_r <= 8'h00;
         src_r <= 2'(SRC_MONITOR);
         mask_r <= '0;
         stat_r <= '0;
         dec_r <= '0;
         gain_r <= DISC_GAIN_RST;
         rx_r <= 1'b0;
         tx_r <= 1'b0;
         rsp_r <= 16'h0000;
         rsp_v_r <= 1'b0;
         ph_r <= P_SLEEP;
         wcnt_r <= 8'h00;
         mod_r <= 1'b0;
      end else begin
         xtal_r <= xtal_nxt;
         bias_r <= bias_nxt;
         auto_r <= auto_nxt;
         hi_r <= hi_nxt;
         lo_r <= lo_nxt;
         ivl_r <= ivl_nxt;
         icnt_r <= icnt_nxt;
         res_r <= res_nxt;
         src_r <= src_nxt;
         mask_r <= mask_nxt;
         stat_r <= stat_nxt;
         dec_r <= dec_nxt;
         gain_r <= gain_nxt;
         rx_r <= rx_nxt;
         tx_r <= tx_nxt;
         rsp_r <= rsp_nxt;
         rsp_v_r <= rsp_v_nxt;
         ph_r <= ph_nxt;
         wcnt_r <= wcnt_nxt;
         mod_r <= mod_nxt;
      end
   end
   assign bus.interrupt_request_line_low = !(|(stat_r & mask_r));
   assign bus.rsp_data = rsp_r;
   assign bus.rsp_valid = rsp_v_r;
   assign xtal_run_o = xtal_r;
   assign bias_on_o = bias_r;
   assign rx_awake_o = rx_r;
   assign tx_awake_o = tx_r;
   assign stage_en_o = (ph_r == P_AWAKE) ? 3'b111 :
      (ph_r == P_STAGE) ? {wcnt_r >= 8'(STAGE_CYCLES * 2), wcnt_r >= 8'(STAGE_CYCLES), 1'b1}
      : 3'b000;
   assign audio_at_bias_o = (ph_r != P_AWAKE);
   assign audio_to_mod_o = mod_r;
   assign decoder_en_o = dec_r;
   assign disc_gain_o = gain_r;
   assign voice_only_o = (dec_r == '0);
   assign result_o = res_r;
endmodule : monitor_device
`default_nettype wire

// ===== hdl/monitor_host.sv
`default_nettype none
module monitor_host
   import monitor_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   monitor_if.host bus,
   input wire logic req_i,
   input wire logic [3:0] req_cmd_i,
   input wire logic [15:0] req_data_i,
   output logic busy_o,
   output logic [15:0] status_o,
   output logic status_valid_o
);
   import monitor_pkg::*;
   logic irq_s0_r, irq_s1_r, pend_r, pend_nxt, v_r, v_nxt, c_r, c_nxt;
   logic [3:0] cmd_r, cmd_nxt;
   logic [15:0] d_r, d_nxt, st_r, st_nxt;
   logic sv_r, sv_nxt;
   always_comb begin
      v_nxt = 1'b0;
      cmd_nxt = cmd_r;
      d_nxt = d_r;
      pend_nxt = pend_r;
      st_nxt = st_r;
      sv_nxt = 1'b0;
      c_nxt = c_r;
      if (bus.rsp_valid) begin
         st_nxt = bus.rsp_data;
         sv_nxt = 1'b1;
         pend_nxt = 1'b0;
      end
      if (!irq_s1_r && !pend_r && !c_r) begin
         v_nxt = 1'b1;
         cmd_nxt = CMD_READ_STATUS;
         pend_nxt = 1'b1;
         c_nxt = 1'b1;
      end else if (req_i) begin
         v_nxt = 1'b1;
         cmd_nxt = req_cmd_i;
         d_nxt = req_data_i;
         if (cmd_t'(req_cmd_i) == CMD_SET_THRESH && req_data_i[7:0] >= req_data_i[15:8]) begin
            d_nxt = {req_data_i[15:8], req_data_i[15:8] - 8'h01};
         end
      end
      if (irq_s1_r) c_nxt = 1'b0;
      else if (c_r && !pend_r) c_nxt = 1'b0;
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_s0_r <= 1'b1;
         irq_s1_r <= 1'b1;
         pend_r <= 1'b0;
         v_r <= 1'b0;
         c_r <= 1'b0;
         cmd_r <= 4'h0;
         d_r <= 16'h0000;
         st_r <= 16'h0000;
         sv_r <= 1'b0;
      end else begin
         irq_s0_r <= bus.interrupt_request_line_low;
         irq_s1_r <= irq_s0_r;
         pend_r <= pend_nxt;
         v_r <= v_nxt;
         c_r <= c_nxt;
         cmd_r <= cmd_nxt;
         d_r <= d_nxt;
         st_r <= st_nxt;
         sv_r <= sv_nxt;
      end
   end
   assign bus.cmd_valid = v_r;
   assign bus.cmd = cmd_r;
   assign bus.cmd_data = d_r;
   assign busy_o = !irq_s1_r && !pend_r && !c_r;
   assign status_o = st_r;
   assign status_valid_o = sv_r;
endmodule : monitor_host
`default_nettype wire

// ===== verification/monitor_chk.sv
`default_nettype none
module monitor_chk
   import monitor_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic cmd_valid,
   input wire logic [3:0] cmd,
   input wire logic [15:0] cmd_data,
   input wire logic [15:0] rsp_data,
   input wire logic rsp_valid,
   input wire logic interrupt_request_line_low
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   a_status_answer: assert property (cmd_valid && cmd == CMD_READ_STATUS |=> rsp_valid)
      else $error("status read got no answer");
   a_result_answer: assert property (cmd_valid && cmd == CMD_READ_RESULT |=> rsp_valid)
      else $error("result read got no answer");
   a_answer_cause: assert property (rsp_valid |-> $past(cmd_valid) &&
      ($past(cmd) == CMD_READ_STATUS || $past(cmd) == CMD_READ_RESULT))
      else $error("answer without a read");
   a_data_held: assert property ($changed(rsp_data) |-> rsp_valid)
      else $error("read data changed without answer");
   a_mask_off: assert property (cmd_valid && cmd == CMD_SET_MASK && cmd_data == 16'h0000
      |=> interrupt_request_line_low[*3])
      else $error("interrupt with all masks clear");
   a_reset_quiet: assert property (cmd_valid && cmd == CMD_GENERAL_RESET
      |=> interrupt_request_line_low[*4])
      else $error("interrupt after general reset");
   a_irq_holds: assert property (!interrupt_request_line_low && !cmd_valid
      |=> !interrupt_request_line_low)
      else $error("interrupt dropped without command");
   a_irq_release: assert property ($rose(interrupt_request_line_low) |-> $past(cmd_valid))
      else $error("interrupt released on its own");
endmodule : monitor_chk
`default_nettype wire

// ===== verification/test_signal_monitor_wake_control.sv
`default_nettype none
module test_signal_monitor_wake_control;
   timeunit 1ns;
   timeprecision 1ps;
   import monitor_pkg::*;
   logic clk_i, nrst_i, req_i, companding_i, voice_active_i, busy_o, status_valid_o;
   logic xtal_run_o, bias_on_o, rx_awake_o, tx_awake_o, audio_at_bias_o, audio_to_mod_o;
   logic voice_only_o, prev_mod;
   logic [3:0] req_cmd_i, disc_gain_o;
   logic [15:0] req_data_i, status_o;
   logic [7:0] smp [4];
   logic [7:0] result_o;
   logic [5:0] detect_i, decoder_en_o;
   logic [2:0] stage_en_o, prev_stage;
   int err_total, compares, cyc;
   logic [15:0] exp_q [$];
   monitor_if bus ();
   monitor_device monitor_device_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus(bus),
      .sample_monitor_i(smp[0]), .sample_first_microphone_input_i(smp[1]), .sample_input2_i(smp[2]),
      .sample_disc_i(smp[3]), .detect_i(detect_i), .companding_i(companding_i),
      .voice_active_i(voice_active_i), .xtal_run_o(xtal_run_o), .bias_on_o(bias_on_o),
      .rx_awake_o(rx_awake_o), .tx_awake_o(tx_awake_o), .stage_en_o(stage_en_o),
      .audio_at_bias_o(audio_at_bias_o), .audio_to_mod_o(audio_to_mod_o),
      .decoder_en_o(decoder_en_o), .disc_gain_o(disc_gain_o), .voice_only_o(voice_only_o),
      .result_o(result_o));
   monitor_host monitor_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus(bus), .req_i(req_i),
      .req_cmd_i(req_cmd_i), .req_data_i(req_data_i), .busy_o(busy_o), .status_o(status_o),
      .status_valid_o(status_valid_o));
   monitor_chk monitor_chk_i (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_valid(bus.cmd_valid),
      .cmd(bus.cmd), .cmd_data(bus.cmd_data), .rsp_data(bus.rsp_data),
      .rsp_valid(bus.rsp_valid), .interrupt_request_line_low(bus.interrupt_request_line_low));
   task automatic final_report;
      if (err_total == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic send(input cmd_t c, input logic [15:0] d);
      @(negedge clk_i);
      while (busy_o !== 1'b0) @(negedge clk_i);
      req_i = 1'b1;
      req_cmd_i = c;
      req_data_i = d;
      @(negedge clk_i);
      req_i = 1'b0;
      repeat (4) @(negedge clk_i);
   endtask : send
   task automatic wait_status(input int b, input string m);
      int n;
      n = 0;
      while (!(status_valid_o === 1'b1 && status_o[b] === 1'b1) && n < 80) begin
         @(negedge clk_i);
         n++;
      end
      chk(n < 80, m);
   endtask : wait_status
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         final_report();
      end
   end
   always @(negedge clk_i) begin
      if (bus.rsp_valid === 1'b1 && exp_q.size() > 0) begin
         chk(bus.rsp_data === exp_q.pop_front(), "result read");
      end
      if (nrst_i && stage_en_o !== prev_stage) begin
         chk($countones(stage_en_o) <= $countones(prev_stage) + 1, "stage jump");
      end
      if (nrst_i && audio_to_mod_o !== prev_mod) begin
         chk(audio_at_bias_o === 1'b1, "switch off bias");
      end
      prev_stage = stage_en_o;
      prev_mod = audio_to_mod_o;
   end
   initial begin
      nrst_i = 1'b0;
      req_i = 1'b0;
      req_cmd_i = 4'h0;
      req_data_i = 16'h0000;
      detect_i = 6'h00;
      companding_i = 1'b0;
      voice_active_i = 1'b0;
      void'($urandom(32'hEA00));
      foreach (smp[i]) smp[i] = 8'(8'h08 * (i + 1)) + 8'($urandom_range(0, 7));
      repeat (20) @(negedge clk_i);
      chk(xtal_run_o === 1'b1 && rx_awake_o === 1'b0 && tx_awake_o === 1'b0, "sleep");
      chk(stage_en_o === 3'h0 && decoder_en_o === 6'h00, "reset stages");
      chk(disc_gain_o === 4'h0, "disc gain");
      nrst_i = 1'b1;
      repeat (INTERVAL_DEF_CYC - 8) @(negedge clk_i);
      chk(result_o === 8'h00, "early conversion");
      repeat (16) @(negedge clk_i);
      chk(result_o === smp[0], "default interval");
      send(CMD_SET_INTERVAL, 16'h0010);
      repeat (INTERVAL_DEF_CYC) @(negedge clk_i);
      for (int s = 0; s < 4; s++) begin
         send(CMD_SET_SOURCE, 16'(s));
         repeat (40) @(negedge clk_i);
         exp_q.push_back({8'h00, smp[s]});
         send(CMD_READ_RESULT, 16'h0000);
         chk(result_o === smp[s], "source result");
      end
      send(CMD_SET_SOURCE, 16'h0000);
      send(CMD_SET_THRESH, 16'h8040);
      send(CMD_SET_MASK, 16'h0001);
      repeat (60) @(negedge clk_i);
      chk(bus.interrupt_request_line_low === 1'b1, "masked low event");
      smp[0] = 8'h81;
      wait_status(ST_HIGH, "high event");
      send(CMD_SET_MASK, 16'h0002);
      smp[0] = 8'h3F;
      wait_status(ST_LOW, "low event");
      smp[0] = 8'h40;
      send(CMD_SET_MASK, 16'h0003);
      repeat (60) @(negedge clk_i);
      chk(bus.interrupt_request_line_low === 1'b1, "between thresholds");
      send(CMD_SET_MASK, 16'h0000);
      send(CMD_SET_DECODERS, 16'h0000);
      chk(voice_only_o === 1'b1, "voice only");
      voice_active_i = 1'b1;
      send(CMD_SET_DECODERS, 16'h000C);
      chk(decoder_en_o === 6'h00, "two voice options");
      send(CMD_SET_DECODERS, 16'h0023);
      chk(decoder_en_o === 6'h23, "one voice option");
      companding_i = 1'b1;
      send(CMD_SET_DECODERS, 16'h0021);
      chk(decoder_en_o === 6'h23, "option with companding");
      voice_active_i = 1'b0;
      companding_i = 1'b0;
      send(CMD_SET_DECODERS, 16'h003F);
      chk(decoder_en_o === 6'h3F && voice_only_o === 1'b0, "all decoders");
      for (int k = 0; k < DEC_W; k++) begin
         send(CMD_SET_MASK, 16'(1 << (ST_DETECT + k)));
         detect_i = 6'(1 << k);
         wait_status(ST_DETECT + k, "detection type");
         detect_i = 6'h00;
         send(CMD_SET_MASK, 16'h0000);
      end
      send(CMD_SET_OPTIONS, 16'h0003);
      send(CMD_SET_SOURCE, 16'h0003);
      smp[3] = 8'h90;
      repeat (40) @(negedge clk_i);
      chk(rx_awake_o === 1'b1 && bias_on_o === 1'b1, "automatic wake");
      smp[3] = 8'h20;
      send(CMD_SET_OPTIONS, 16'h0001);
      send(CMD_WAKE_RX, 16'h0000);
      repeat (60) @(negedge clk_i);
      chk(stage_en_o === 3'h7 && rx_awake_o === 1'b1, "receive wake");
      send(CMD_WAKE_TX, 16'h0000);
      repeat (60) @(negedge clk_i);
      chk(tx_awake_o === 1'b1 && audio_to_mod_o === 1'b1 && stage_en_o === 3'h7, "tx route");
      send(CMD_XTAL_SAVE, 16'h0000);
      chk(xtal_run_o === 1'b0, "crystal save");
      send(CMD_XTAL_RUN, 16'h0000);
      send(CMD_GENERAL_RESET, 16'h0000);
      chk(xtal_run_o === 1'b1 && rx_awake_o === 1'b0 && tx_awake_o === 1'b0, "reset");
      chk(bias_on_o === 1'b0 && decoder_en_o === 6'h00, "reset sleep");
      chk(exp_q.size() == 0, "missing read answer");
      final_report();
   end
endmodule : test_signal_monitor_wake_control
`default_nettype wire
